// >>> rtl/pst_pkg.sv
package pst_pkg;

  // Channel count and data widths.
  localparam int unsigned NUM_CHAN   = 8;
  localparam int unsigned PAGE_W     = 3;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned BYTE_W     = 8;

  // Command codes used to select a readback register.
  localparam logic [7:0] CMD_INPUT_STATUS  = 8'h7C;
  localparam logic [7:0] CMD_TEMP_STATUS   = 8'h7D;
  localparam logic [7:0] CMD_CML_STATUS    = 8'h7E;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_VIN_READ      = 8'h88;
  localparam logic [7:0] CMD_VOUT_READ     = 8'h8B;
  localparam logic [7:0] CMD_TEMP_READ     = 8'h8D;
  localparam logic [7:0] CMD_REVISION      = 8'h98;

  // Fixed revision code and reset values.
  localparam logic [7:0]  STD_REVISION_VAL = 8'h11;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [15:0] WORD_ZERO        = 16'h0000;

  // Field positions inside the status bytes.
  localparam int unsigned B_OV_FAULT  = 7;
  localparam int unsigned B_OV_WARN   = 6;
  localparam int unsigned B_UV_WARN   = 5;
  localparam int unsigned B_UV_FAULT  = 4;
  localparam int unsigned B_VIN_OFF   = 3;
  localparam int unsigned B_CML_CMD   = 7;
  localparam int unsigned B_CML_DATA  = 6;
  localparam int unsigned B_CML_PEC   = 5;
  localparam int unsigned B_CML_MEM   = 4;
  localparam int unsigned B_CML_BUS   = 1;
  localparam int unsigned B_MFR_DISCH = 7;
  localparam int unsigned B_MFR_FLT1  = 6;
  localparam int unsigned B_MFR_FLT0  = 5;
  localparam int unsigned B_MFR_SERVO = 4;
  localparam int unsigned B_MFR_DAC   = 3;
  localparam int unsigned B_MFR_SAT   = 2;
  localparam int unsigned B_MFR_VINEN = 1;
  localparam int unsigned B_MFR_WDOG  = 0;

  // Read port sequencing.
  typedef enum logic [1:0] {
    PST_IDLE = 2'b01,
    PST_HOLD = 2'b10
  } pst_rd_state_t;

endpackage : pst_pkg

// >>> rtl/pst_status_regs.sv
`timescale 1ns/10ps
`default_nettype none

module pst_status_regs
  import pst_pkg::*;
#(
  parameter int unsigned NCH = pst_pkg::NUM_CHAN
)
(
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // Command decode side of the serial interface.
  input  wire logic                       rd_req,
  input  wire logic [7:0]                 rd_cmd,
  input  wire logic [pst_pkg::PAGE_W-1:0] page_sel,
  output logic                            rd_valid,
  output logic [pst_pkg::WORD_W-1:0]      rd_data,
  // Communication fault events, one-cycle pulses from the protocol engine.
  input  wire logic                       cml_bad_cmd,
  input  wire logic                       cml_bad_data,
  input  wire logic                       cml_extra_byte,
  input  wire logic                       cml_pec_match,
  input  wire logic                       cml_malformed,
  input  wire logic                       eeprom_fault,
  input  wire logic                       clear_faults,
  // Supervisor levels.
  input  wire logic                       vin_ov_fault,
  input  wire logic                       vin_ov_warn,
  input  wire logic                       vin_uv_warn,
  input  wire logic                       vin_uv_fault,
  input  wire logic                       vin_unit_off,
  input  wire logic                       ot_fault,
  input  wire logic                       ot_warn,
  input  wire logic                       ut_warn,
  input  wire logic                       ut_fault,
  // Per-channel events and levels, then the shared fault pins and global flags.
  input  wire logic [NCH-1:0]             chan_cmd_on,
  input  wire logic [NCH-1:0]             chan_turning_on,
  input  wire logic [NCH-1:0]             chan_fault1_shutdown,
  input  wire logic [NCH-1:0]             chan_fault0_shutdown,
  input  wire logic [NCH-1:0]             discharge_fault,
  input  wire logic [NCH-1:0]             servo_reached,
  input  wire logic [NCH-1:0]             trim_driver_output,
  input  wire logic [NCH-1:0]             servo_end_saturated,
  input  wire logic [NCH-1:0]             adc_hires,
  input  wire logic                       shared_fault_line1_n,
  input  wire logic                       shared_fault_line0_n,
  input  wire logic                       vinen_faulted_off,
  input  wire logic                       watchdog_expired,
  // ADC results, each with a one-cycle update strobe, then the alert output.
  input  wire logic                       vin_adc_upd,
  input  wire logic [pst_pkg::WORD_W-1:0] vin_adc_l11,
  input  wire logic                       temp_adc_upd,
  input  wire logic [pst_pkg::WORD_W-1:0] temp_adc_l11,
  input  wire logic [NCH-1:0]             vout_adc_upd,
  input  wire logic [pst_pkg::WORD_W-1:0] vout_adc_word,
  output logic                            alert_out_n
);

  import pst_pkg::*;

  // Sampled fault pins; the first stage is read only by the second.
  logic [1:0] flt1_sync_r;
  logic [1:0] flt0_sync_r;

  logic [BYTE_W-1:0] comm_r;
  logic [NCH-1:0]    disch_r;
  logic [NCH-1:0]    flt1_r;
  logic [NCH-1:0]    flt0_r;
  logic [NCH-1:0]    sat_r;
  logic              wdog_r;
  logic [WORD_W-1:0] vin_word_r;
  logic [WORD_W-1:0] temp_word_r;
  logic [WORD_W-1:0] vout_word_r [NCH];
  logic [WORD_W-1:0] rd_data_nxt;
  logic [BYTE_W-1:0] in_stat;
  logic [BYTE_W-1:0] tmp_stat;
  logic [BYTE_W-1:0] mfr_stat;
  logic              alert_nxt;
  pst_rd_state_t     rd_state_r;

  // Pins come from outside the clock domain, so two flops first.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      flt1_sync_r <= 2'h3;
      flt0_sync_r <= 2'h3;
    end
    else
    begin
      flt1_sync_r <= {flt1_sync_r[0], shared_fault_line1_n};
      flt0_sync_r <= {flt0_sync_r[0], shared_fault_line0_n};
    end
  end

  // Comm flags are sticky; a new event in the clear cycle wins.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      comm_r <= BYTE_ZERO;
    else
    begin
      if (clear_faults)
        comm_r <= BYTE_ZERO;
      if (cml_bad_cmd)
        comm_r[B_CML_CMD] <= 1'b1;
      if (cml_bad_data)
        comm_r[B_CML_DATA] <= 1'b1;
      if (cml_extra_byte && !cml_pec_match)
        comm_r[B_CML_PEC] <= 1'b1;
      if (eeprom_fault)
        comm_r[B_CML_MEM] <= 1'b1;
      if (cml_malformed)
        comm_r[B_CML_BUS] <= 1'b1;
    end
  end

  // Per-channel sticky vendor bits, cleared by clear-faults or a turn-on
  // command for that channel; the set still wins in the same cycle.
  generate
    for (genvar c = 0; c < NCH; c++)
    begin : g_chan
      logic clr;
      assign clr = clear_faults | chan_cmd_on[c];

      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          disch_r[c] <= 1'b0;
          flt1_r[c]  <= 1'b0;
          flt0_r[c]  <= 1'b0;
          sat_r[c]   <= 1'b0;
        end
        else
        begin
          disch_r[c] <= (disch_r[c] & ~clr) |
                        (discharge_fault[c] & chan_turning_on[c]);
          flt1_r[c]  <= (flt1_r[c] & ~clr) | chan_fault1_shutdown[c] |
                        (chan_turning_on[c] & ~flt1_sync_r[1]);
          flt0_r[c]  <= (flt0_r[c] & ~clr) | chan_fault0_shutdown[c] |
                        (chan_turning_on[c] & ~flt0_sync_r[1]);
          sat_r[c]   <= (sat_r[c] & ~clr) | servo_end_saturated[c];
        end
      end

      // Latest ADC result for this channel, held until the next conversion.
      always_ff @(posedge clk)
      begin
        if (!rst_b)
          vout_word_r[c] <= WORD_ZERO;
        else if (vout_adc_upd[c])
          vout_word_r[c] <= vout_adc_word;
      end
    end
  endgenerate

  // Global watchdog flag clears only with clear-faults, set wins.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      wdog_r <= 1'b0;
    else
      wdog_r <= (wdog_r & ~clear_faults) | watchdog_expired;
  end

  // Input voltage and die temperature readbacks.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      vin_word_r  <= WORD_ZERO;
      temp_word_r <= WORD_ZERO;
    end
    else
    begin
      if (vin_adc_upd)
        vin_word_r <= vin_adc_l11;
      if (temp_adc_upd)
        temp_word_r <= temp_adc_l11;
    end
  end

  // Assemble the status bytes; unsupported positions stay zero.
  always_comb
  begin
    in_stat = BYTE_ZERO;
    in_stat[B_OV_FAULT] = vin_ov_fault;
    in_stat[B_OV_WARN]  = vin_ov_warn;
    in_stat[B_UV_WARN]  = vin_uv_warn;
    in_stat[B_UV_FAULT] = vin_uv_fault;
    in_stat[B_VIN_OFF]  = vin_unit_off;
    tmp_stat = BYTE_ZERO;
    tmp_stat[B_OV_FAULT] = ot_fault;
    tmp_stat[B_OV_WARN]  = ot_warn;
    tmp_stat[B_UV_WARN]  = ut_warn;
    tmp_stat[B_UV_FAULT] = ut_fault;
    mfr_stat = BYTE_ZERO;
    mfr_stat[B_MFR_DISCH] = disch_r[page_sel];
    mfr_stat[B_MFR_FLT1]  = flt1_r[page_sel];
    mfr_stat[B_MFR_FLT0]  = flt0_r[page_sel];
    mfr_stat[B_MFR_SERVO] = servo_reached[page_sel];
    mfr_stat[B_MFR_DAC]   = trim_driver_output[page_sel];
    mfr_stat[B_MFR_SAT]   = sat_r[page_sel];
    mfr_stat[B_MFR_VINEN] = vinen_faulted_off;
    mfr_stat[B_MFR_WDOG]  = wdog_r;
  end

  // Read mux; a read only selects, it never touches any flag.
  always_comb
  begin
    rd_data_nxt = WORD_ZERO;
    case (rd_cmd)
      CMD_INPUT_STATUS:  rd_data_nxt = {BYTE_ZERO, in_stat};
      CMD_TEMP_STATUS:   rd_data_nxt = {BYTE_ZERO, tmp_stat};
      CMD_CML_STATUS:    rd_data_nxt = {BYTE_ZERO, comm_r};
      CMD_VENDOR_STATUS: rd_data_nxt = {BYTE_ZERO, mfr_stat};
      CMD_VIN_READ:      rd_data_nxt = vin_word_r;
      CMD_VOUT_READ:     rd_data_nxt = vout_word_r[page_sel];
      CMD_TEMP_READ:     rd_data_nxt = temp_word_r;
      CMD_REVISION:      rd_data_nxt = {BYTE_ZERO, STD_REVISION_VAL};
      default:           rd_data_nxt = WORD_ZERO;
    endcase
  end

  // Answer one cycle after the request with a one-cycle valid pulse.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rd_state_r <= PST_IDLE;
      rd_valid   <= 1'b0;
      rd_data    <= WORD_ZERO;
    end
    else
    begin
      case (rd_state_r)
        PST_IDLE:
        begin
          rd_valid <= rd_req;
          if (rd_req)
          begin
            rd_data    <= rd_data_nxt;
            rd_state_r <= PST_HOLD;
          end
        end
        PST_HOLD:
        begin
          rd_valid   <= 1'b0;
          rd_state_r <= PST_IDLE;
        end
        default:
        begin
          rd_valid   <= 1'b0;
          rd_state_r <= PST_IDLE;
        end
      endcase
    end
  end

  // Alert is held low while any alerting flag is set on any channel, so
  // a host on a different page still sees it.
  assign alert_nxt = |disch_r | |flt1_r | |flt0_r | wdog_r;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      alert_out_n <= 1'b1;
    else
      alert_out_n <= ~alert_nxt;
  end

endmodule : pst_status_regs
`default_nettype wire

// >>> sim/pst_status_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the read port and the alert pin of the status bank.
module pst_status_regs_assertions
  import pst_pkg::*;
#(
  parameter int unsigned NCH = 8
)
(
  input wire logic           clk,
  input wire logic           rst_b,
  input wire logic           rd_req,
  input wire logic [7:0]     rd_cmd,
  input wire logic           rd_valid,
  input wire logic [15:0]    rd_data,
  input wire logic           clear_faults,
  input wire logic           watchdog_expired,
  input wire logic [NCH-1:0] chan_cmd_on,
  input wire logic           alert_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A request while no answer stands is taken; the cycle after is refused.
  a_read_answered: assert property (rd_req && !rd_valid |=> rd_valid)
    else $error("read not answered");
  a_valid_single: assert property (rd_valid |=> !rd_valid)
    else $error("valid longer than one cycle");
  a_valid_caused: assert property (rd_valid |-> $past(rd_req))
    else $error("valid without request");
  a_data_holds: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved between reads");
  a_rev_fixed: assert property (rd_valid && $past(rd_cmd) == CMD_REVISION
    |-> rd_data == 16'h0011) else $error("revision byte wrong");
  a_input_zeros: assert property (rd_valid
    && $past(rd_cmd) == CMD_INPUT_STATUS |-> rd_data[2:0] == 3'h0)
    else $error("input status low bits set");
  a_temp_zeros: assert property (rd_valid
    && $past(rd_cmd) == CMD_TEMP_STATUS |-> rd_data[3:0] == 4'h0)
    else $error("temperature status low bits set");
  a_cml_zeros: assert property (rd_valid
    && $past(rd_cmd) == CMD_CML_STATUS |-> {rd_data[3:2], rd_data[0]} == 3'h0)
    else $error("comm status unused bits set");
  a_wdog_alert: assert property (watchdog_expired |-> ##[1:3] !alert_out_n)
    else $error("watchdog did not pull alert");
  // Both clear events act one edge late, so their previous value is masked.
  a_alert_sticky: assert property (!alert_out_n && !clear_faults
    && !$past(clear_faults) && chan_cmd_on == '0 && $past(chan_cmd_on) == '0
    |=> !alert_out_n) else $error("alert released without clear");

  c_rev_read: cover property (rd_valid && $past(rd_cmd) == CMD_REVISION);
  c_alert_low: cover property ($fell(alert_out_n));
  c_vendor_read: cover property (rd_valid && $past(rd_cmd) == CMD_VENDOR_STATUS);
endmodule : pst_status_regs_assertions
`default_nettype wire

// >>> sim/pst_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host side of the read port: one read at a time, at least two cycles apart.
module pst_host_model
(
  input  wire logic        clk,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  output var  logic        rd_req,
  output var  logic [7:0]  rd_cmd,
  output var  logic [2:0]  page_sel
);
  initial
  begin
    rd_req = 1'h0;
    rd_cmd = 8'hA5;
    page_sel = 3'h5;
  end

  // Released lines are inverted so a late sample in the bank cannot pass.
  task automatic read(input logic [7:0] c, input logic [2:0] p,
                      output logic [15:0] d);
    @(negedge clk);
    rd_req = 1'h1;
    rd_cmd = c;
    page_sel = p;
    @(negedge clk);
    rd_req = 1'h0;
    rd_cmd = ~c;
    page_sel = ~p;
    d = rd_valid ? rd_data : 16'hXXXX;
  endtask : read
endmodule : pst_host_model
`default_nettype wire

// >>> sim/test_pst_status_regs.sv
`timescale 1ns/10ps
`default_nettype none
module test_pst_status_regs;
  import pst_pkg::*;
  logic clk = 1'h0, rst_b = 1'h0, rd_req, rd_valid, alert_out_n;
  logic [7:0] rd_cmd;
  logic [2:0] page_sel;
  logic [15:0] rd_data, got;
  logic cml_bad_cmd = 0, cml_bad_data = 0, cml_extra_byte = 0;
  logic cml_pec_match = 0, cml_malformed = 0, eeprom_fault = 0;
  logic clear_faults = 0, vin_ov_fault = 0, vin_ov_warn = 0, vin_uv_warn = 0;
  logic vin_uv_fault = 0, vin_unit_off = 0, ot_fault = 0, ot_warn = 0;
  logic ut_warn = 0, ut_fault = 0, shared_fault_line1_n = 1;
  logic shared_fault_line0_n = 1, vinen_faulted_off = 0, watchdog_expired = 0;
  logic vin_adc_upd = 0, temp_adc_upd = 0;
  logic [7:0] chan_cmd_on = 0, chan_turning_on = 0, chan_fault1_shutdown = 0;
  logic [7:0] chan_fault0_shutdown = 0, discharge_fault = 0, servo_reached = 0;
  logic [7:0] trim_driver_output = 0, servo_end_saturated = 0, adc_hires = 0;
  logic [7:0] vout_adc_upd = 0;
  logic [15:0] vin_adc_l11 = 0, temp_adc_l11 = 0, vout_adc_word = 0;
  int mismatches = 0, samples_checked = 0, cycles = 0;

  pst_status_regs #(.NCH(8)) pst_status_regs_inst (.*);
  pst_host_model pst_host_model_inst (.*);

  always #2.5 clk = ~clk;

  task step;
    @(negedge clk);
  endtask : step

  task rd(input logic [7:0] c, input logic [2:0] p);
    pst_host_model_inst.read(c, p, got);
  endtask : rd

  task chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task conclude;
    $display("compared %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task test_supply;
    rd(CMD_REVISION, 3'h0);
    chk("revision", 16'h0011, got);
    rd(8'h00, 3'h0);
    chk("unmapped", 16'h0000, got);
    step;
    {vin_ov_fault, vin_uv_warn, vin_unit_off, ot_fault, ut_warn} = 5'h1F;
    rd(CMD_INPUT_STATUS, 3'h0);
    chk("input status", 16'h00A8, got);
    rd(CMD_TEMP_STATUS, 3'h0);
    chk("temp status", 16'h00A0, got);
    {vin_ov_fault, vin_ov_warn, vin_uv_warn, vin_uv_fault, vin_unit_off} = 5'h0A;
    {ot_fault, ot_warn, ut_warn, ut_fault} = 4'h5;
    rd(CMD_INPUT_STATUS, 3'h0);
    chk("input live", 16'h0050, got);
    rd(CMD_TEMP_STATUS, 3'h0);
    chk("temp live", 16'h0050, got);
    $display("supply test done");
  endtask : test_supply

  task test_cml;
    {cml_bad_cmd, cml_extra_byte, cml_pec_match} = 3'h7;
    step;
    {cml_bad_cmd, cml_extra_byte, cml_pec_match} = 3'h0;
    rd(CMD_CML_STATUS, 3'h0);
    chk("cml cmd", 16'h0080, got);
    {cml_bad_data, eeprom_fault, cml_malformed, cml_extra_byte} = 4'hF;
    step;
    {cml_bad_data, eeprom_fault, cml_malformed, cml_extra_byte} = 4'h0;
    repeat (2) rd(CMD_CML_STATUS, 3'h0);
    chk("cml all", 16'h00F2, got);
    clear_faults = 1;
    step;
    clear_faults = 0;
    rd(CMD_CML_STATUS, 3'h0);
    chk("cml cleared", 16'h0000, got);
    $display("comm test done");
  endtask : test_cml

  task test_vendor;
    shared_fault_line1_n = 0;
    {servo_reached[2], trim_driver_output[2], vinen_faulted_off} = 3'h7;
    repeat (3) step;
    {chan_turning_on[2], discharge_fault[2], watchdog_expired} = 3'h7;
    {servo_end_saturated[2], chan_fault0_shutdown[2]} = 2'h3;
    step;
    {chan_turning_on[2], discharge_fault[2], watchdog_expired} = 3'h0;
    {servo_end_saturated[2], chan_fault0_shutdown[2]} = 2'h0;
    shared_fault_line1_n = 1;
    rd(CMD_VENDOR_STATUS, 3'h2);
    chk("vendor page2", 16'h00FF, got);
    chk("alert low", 16'h0000, {15'h0, alert_out_n});
    rd(CMD_VENDOR_STATUS, 3'h3);
    chk("vendor page3", 16'h0003, got);
    chan_cmd_on[2] = 1;
    step;
    chan_cmd_on[2] = 0;
    rd(CMD_VENDOR_STATUS, 3'h2);
    chk("vendor cmd on", 16'h001B, got);
    {servo_reached[2], trim_driver_output[2], vinen_faulted_off} = 3'h0;
    clear_faults = 1;
    step;
    clear_faults = 0;
    servo_end_saturated[2] = 1;
    step;
    servo_end_saturated[2] = 0;
    rd(CMD_VENDOR_STATUS, 3'h2);
    chk("vendor saturated", 16'h0004, got);
    chk("alert high", 16'h0001, {15'h0, alert_out_n});
    $display("vendor test done");
  endtask : test_vendor

  task test_adc;
    rd(CMD_VIN_READ, 3'h0);
    chk("vin reset", 16'h0000, got);
    {vin_adc_upd, temp_adc_upd, vout_adc_upd, adc_hires} = 18'h3_2020;
    {vin_adc_l11, temp_adc_l11, vout_adc_word} = 48'hD3A5_E123_1234;
    step;
    {vin_adc_upd, temp_adc_upd, vout_adc_upd} = 10'h010;
    {vin_adc_l11, vout_adc_word} = 32'h0000_8765;
    step;
    vout_adc_upd = 0;
    rd(CMD_VIN_READ, 3'h0);
    chk("vin word", 16'hD3A5, got);
    rd(CMD_TEMP_READ, 3'h0);
    chk("temp word", 16'hE123, got);
    rd(CMD_VOUT_READ, 3'h5);
    chk("vout ch5", 16'h1234, got);
    rd(CMD_VOUT_READ, 3'h4);
    chk("vout ch4", 16'h8765, got);
    $display("adc test done");
  endtask : test_adc

  // Ceiling sits well above the roughly 56 cycles the tests need.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    repeat (5) step;
    rst_b = 1;
    test_adc();
    test_supply();
    test_cml();
    test_vendor();
    conclude();
  end
endmodule : test_pst_status_regs

bind pst_status_regs pst_status_regs_assertions #(.NCH(NCH))
  pst_status_regs_assertions_inst (.*);
`default_nettype wire
